/* File: hdl/uart_regs_pkg.sv */
package uart_regs_pkg;
  localparam logic [3:0] OFS_HOLDING = 4'h0;
  localparam logic [3:0] OFS_INT_ENABLES = 4'h1;
  localparam logic [7:0] RST_HOLDING = 8'h00;
  localparam logic [7:0] RST_DIVISOR_LOW = 8'h01;
  localparam logic [7:0] RST_INT_ENABLES = 8'h00;
  localparam logic [7:0] LCR_ENHANCED_ACCESS = 8'hBF;
  localparam int LCR_DIV_ACCESS_BIT = 7;
  localparam int EFR_ENHANCED_BIT = 4;
  localparam int IE_CTS_BIT = 7;
  localparam int IE_RTS_BIT = 6;
  localparam int IE_XOFF_BIT = 5;
  localparam int IE_SLEEP_BIT = 4;
  localparam int IE_MODEM_BIT = 3;
  localparam int IE_LINE_STATUS_BIT = 2;
  localparam int IE_TX_READY_BIT = 1;
  localparam int IE_RX_READY_BIT = 0;
  localparam int FIFO_DEPTH = 64;
  localparam logic [6:0] TX_TRIG_0 = 7'd8;
  localparam logic [6:0] TX_TRIG_1 = 7'd16;
  localparam logic [6:0] TX_TRIG_2 = 7'd32;
  localparam logic [6:0] TX_TRIG_3 = 7'd56;
endpackage : uart_regs_pkg

/* File: hdl/char_fifo.sv */
`timescale 1ns/1ps
module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic clear_i,
  input wire logic fifo_mode_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] push_data_i,
  input wire logic pop_i,
  output logic [WIDTH-1:0] head_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] wr_ptr;
  logic [AW:0] cap;
  logic do_push;
  logic do_pop;

  // Single slot outside fifo mode
  assign cap = fifo_mode_i ? (AW+1)'(DEPTH) : (AW+1)'(1);
  assign do_push = push_i && (count_o < cap);
  assign do_pop = pop_i && (count_o != '0);
  assign head_o = mem[rd_ptr];

  always_ff @(posedge mclk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count_o <= '0;
    end else if (clear_i) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count_o <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count_o <= count_o + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : char_fifo

/* File: hdl/uart_holding_and_irq_enable_regs.sv */
`timescale 1ns/1ps
// Contract
// - Offset 0, divisor access clear: holding registers
// - Receive read pops oldest receive entry
// - Transmit write appends; dropped when full
// - Divisor low at 0 when access, not enhanced
// - Divisor low is one, power-on reset only
// - Interrupt enables at offset 1, reset zero
// - Upper enable bits need enhanced enable
// - Bits 7,6,5 enable flow change interrupts
// - Bits 3,2,0 enable modem, line, data
// - Bit 1 enables transmit-ready on free space
// - Sleep only when idle, quiet, empty
// - Wake on modem toggle, rx low, tx write
// - Sleep stops oscillator and gates clock
// - Fifo mode holds sixty-four, else one
// - Transmit trigger codes 8,16,32,56 spaces
module uart_holding_and_irq_enable_regs
  import uart_regs_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic soft_rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] line_control_i,
  input wire logic enhanced_en_i,
  input wire logic fifo_en_i,
  input wire logic [1:0] tx_trigger_i,
  input wire logic rx_fifo_clear_i,
  input wire logic tx_fifo_clear_i,
  input wire logic rx_push_i,
  input wire logic [7:0] rx_data_i,
  input wire logic tx_pop_i,
  input wire logic int_pending_i,
  input wire logic modem_change_i,
  input wire logic rx_pin_i,
  output logic [7:0] tx_head_o,
  output logic tx_avail_o,
  output logic rx_avail_o,
  output logic [7:0] divisor_low_o,
  output logic [7:0] int_enables_o,
  output logic tx_ready_irq_o,
  output logic sleep_o,
  output logic osc_en_o
);
  localparam int CW = $clog2(DEPTH) + 1;
  logic [7:0] int_enables;
  logic [7:0] divisor_low;
  logic [7:0] rx_head;
  logic [7:0] tx_head_c;
  logic [CW-1:0] rx_count;
  logic [CW-1:0] tx_count;
  logic [CW-1:0] tx_free;
  logic [6:0] tx_thresh;
  logic div_access;
  logic sel_hold;
  logic sel_div;
  logic sel_ie;
  logic tx_write;
  logic rx_read;
  logic tx_ok;
  logic can_sleep;
  logic wake;
  logic next_tx_ready;
  logic soft_clr;
  logic [7:0] ie_mask;

  typedef enum logic [0:0] {AWAKE, ASLEEP} power_e;
  power_e power_state;

  assign div_access = line_control_i[LCR_DIV_ACCESS_BIT];
  assign sel_hold = (reg_addr_i == OFS_HOLDING) && !div_access;
  assign sel_div = (reg_addr_i == OFS_HOLDING) && div_access
                   && (line_control_i != LCR_ENHANCED_ACCESS);
  assign sel_ie = (reg_addr_i == OFS_INT_ENABLES) && !div_access;
  assign tx_write = reg_wr_i && sel_hold;
  assign rx_read = reg_rd_i && sel_hold;
  assign soft_clr = soft_rst_i;

  char_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .clear_i(rx_fifo_clear_i || soft_clr),
    .fifo_mode_i(fifo_en_i),
    .push_i(rx_push_i),
    .push_data_i(rx_data_i),
    .pop_i(rx_read),
    .head_o(rx_head),
    .count_o(rx_count)
  );

  char_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .clear_i(tx_fifo_clear_i || soft_clr),
    .fifo_mode_i(fifo_en_i),
    .push_i(tx_write),
    .push_data_i(reg_wdata_i),
    .pop_i(tx_pop_i),
    .head_o(tx_head_c),
    .count_o(tx_count)
  );

  assign tx_ok = fifo_en_i ? (tx_count < CW'(DEPTH)) : (tx_count == '0);

  // Read data; empty receive read returns whatever the head slot holds
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= RST_HOLDING;
    end else if (soft_clr) begin
      reg_rdata_o <= RST_HOLDING;
    end else if (rx_read) begin
      reg_rdata_o <= rx_head;
    end else if (reg_rd_i && sel_ie) begin
      reg_rdata_o <= int_enables;
    end else if (reg_rd_i) begin
      reg_rdata_o <= 8'h00;
    end
  end

  // Divisor low survives software reset
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      divisor_low <= RST_DIVISOR_LOW;
    end else if (reg_wr_i && sel_div) begin
      divisor_low <= reg_wdata_i;
    end
  end

  assign ie_mask = enhanced_en_i ? 8'hFF : 8'h0F;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_enables <= RST_INT_ENABLES;
    end else if (soft_clr) begin
      int_enables <= RST_INT_ENABLES;
    end else if (reg_wr_i && sel_ie) begin
      int_enables <= (reg_wdata_i & ie_mask) | (int_enables & ~ie_mask);
    end
  end

  always_comb begin
    case (tx_trigger_i)
      2'b00: tx_thresh = TX_TRIG_0;
      2'b01: tx_thresh = TX_TRIG_1;
      2'b10: tx_thresh = TX_TRIG_2;
      2'b11: tx_thresh = TX_TRIG_3;
      default: tx_thresh = TX_TRIG_0;
    endcase
  end

  assign tx_free = CW'(DEPTH) - tx_count;
  assign next_tx_ready = int_enables[IE_TX_READY_BIT] &&
    (fifo_en_i ? (tx_free > CW'(tx_thresh)) : (tx_count == '0));

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_ready_irq_o <= 1'b0;
    end else begin
      tx_ready_irq_o <= next_tx_ready;
    end
  end

  assign can_sleep = int_enables[IE_SLEEP_BIT] && !int_pending_i && !modem_change_i
                     && rx_pin_i && (rx_count == '0) && (tx_count == '0);
  assign wake = modem_change_i || !rx_pin_i || tx_write;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      power_state <= AWAKE;
    end else begin
      case (power_state)
        AWAKE: begin
          if (can_sleep && !tx_write) begin
            power_state <= ASLEEP;
          end
        end
        ASLEEP: begin
          if (wake || !int_enables[IE_SLEEP_BIT]) begin
            power_state <= AWAKE;
          end
        end
        default: power_state <= AWAKE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sleep_o <= 1'b0;
      osc_en_o <= 1'b1;
      tx_head_o <= 8'h00;
      tx_avail_o <= 1'b0;
      rx_avail_o <= 1'b0;
      divisor_low_o <= RST_DIVISOR_LOW;
      int_enables_o <= RST_INT_ENABLES;
    end else begin
      sleep_o <= (power_state == ASLEEP);
      osc_en_o <= (power_state != ASLEEP);
      tx_head_o <= tx_head_c;
      tx_avail_o <= (tx_count != '0);
      rx_avail_o <= (rx_count != '0);
      divisor_low_o <= divisor_low;
      int_enables_o <= int_enables;
    end
  end

  property p_div_write;
    @(posedge mclk_i) disable iff (!nrst_i)
      (reg_wr_i && sel_div) |=> (divisor_low == $past(reg_wdata_i));
  endproperty
  a_div_write: assert property (p_div_write) else $error("divisor write lost");

  property p_div_soft;
    @(posedge mclk_i) disable iff (!nrst_i)
      (soft_rst_i && !(reg_wr_i && sel_div)) |=> $stable(divisor_low);
  endproperty
  a_div_soft: assert property (p_div_soft) else $error("divisor changed by soft reset");

  property p_ie_upper;
    @(posedge mclk_i) disable iff (!nrst_i)
      (!enhanced_en_i && !soft_rst_i) |=> (int_enables[7:4] == $past(int_enables[7:4]));
  endproperty
  a_ie_upper: assert property (p_ie_upper) else $error("upper enables changed");

  property p_ie_write;
    @(posedge mclk_i) disable iff (!nrst_i)
      (reg_wr_i && sel_ie && !soft_rst_i) |=> (int_enables[3:0] == $past(reg_wdata_i[3:0]));
  endproperty
  a_ie_write: assert property (p_ie_write) else $error("enable write lost");

  property p_rx_pop;
    @(posedge mclk_i) disable iff (!nrst_i)
      (rx_read && rx_count != '0 && !rx_push_i && !rx_fifo_clear_i && !soft_rst_i)
        |=> (rx_count == $past(rx_count) - CW'(1));
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("receive read did not pop");

  property p_tx_push;
    @(posedge mclk_i) disable iff (!nrst_i)
      (tx_write && !tx_pop_i && !tx_fifo_clear_i && !soft_rst_i)
        |=> (tx_count == $past(tx_count) + CW'($past(tx_ok)));
  endproperty
  a_tx_push: assert property (p_tx_push) else $error("transmit push wrong");

  property p_sleep_cond;
    @(posedge mclk_i) disable iff (!nrst_i)
      (power_state == AWAKE && !can_sleep) |=> (power_state == AWAKE);
  endproperty
  a_sleep_cond: assert property (p_sleep_cond) else $error("slept while busy");

  property p_wake;
    @(posedge mclk_i) disable iff (!nrst_i)
      (power_state == ASLEEP && wake) |=> (power_state == AWAKE) ##1 osc_en_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

  property p_tx_ready;
    @(posedge mclk_i) disable iff (!nrst_i)
      (int_enables[IE_TX_READY_BIT] && !fifo_en_i && tx_count == '0) |=> tx_ready_irq_o;
  endproperty
  a_tx_ready: assert property (p_tx_ready) else $error("tx ready missing");

  property p_rd_hold;
    @(posedge mclk_i) disable iff (!nrst_i)
      (rx_read && !soft_rst_i) |=> (reg_rdata_o == $past(rx_head));
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("receive read data wrong");

  property p_rd_ie;
    @(posedge mclk_i) disable iff (!nrst_i)
      (reg_rd_i && sel_ie && !soft_rst_i) |=> (reg_rdata_o == $past(int_enables));
  endproperty
  a_rd_ie: assert property (p_rd_ie) else $error("enable read data wrong");

  property p_rd_unmapped;
    @(posedge mclk_i) disable iff (!nrst_i)
      (reg_rd_i && !sel_hold && !sel_ie && !soft_rst_i) |=> (reg_rdata_o == 8'h00);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  property p_div_blocked;
    @(posedge mclk_i) disable iff (!nrst_i)
      (reg_wr_i && (reg_addr_i == OFS_HOLDING) && (line_control_i == LCR_ENHANCED_ACCESS))
        |=> $stable(divisor_low);
  endproperty
  a_div_blocked: assert property (p_div_blocked) else $error("divisor written in enhanced");

  property p_ie_mirror;
    @(posedge mclk_i) disable iff (!nrst_i)
      1'b1 |=> (int_enables_o == $past(int_enables));
  endproperty
  a_ie_mirror: assert property (p_ie_mirror) else $error("enable bits not mirrored");

  property p_sleep_gate;
    @(posedge mclk_i) disable iff (!nrst_i)
      (power_state == ASLEEP) |=> (sleep_o && !osc_en_o);
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("clock not gated in sleep");

  property p_tx_full_irq;
    @(posedge mclk_i) disable iff (!nrst_i)
      (fifo_en_i && (tx_count == CW'(DEPTH))) |=> !tx_ready_irq_o;
  endproperty
  a_tx_full_irq: assert property (p_tx_full_irq) else $error("tx ready while full");

  property p_tx_empty_irq;
    @(posedge mclk_i) disable iff (!nrst_i)
      (int_enables[IE_TX_READY_BIT] && fifo_en_i && (tx_count == '0)) |=> tx_ready_irq_o;
  endproperty
  a_tx_empty_irq: assert property (p_tx_empty_irq) else $error("tx ready missing empty");
endmodule : uart_holding_and_irq_enable_regs

/* File: tb/host_model.sv */
`timescale 1ns/1ps
module host_model (
  input wire logic mclk_i,
  output logic [3:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  initial begin
    reg_addr_o = 4'hF;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end

  // One strobe cycle, then strobes drop low and address and data lines show the inverse of what they carried
  task automatic access(input logic wr, input logic [3:0] addr, input logic [7:0] data);
    @(posedge mclk_i);
    reg_addr_o <= addr;
    reg_wdata_o <= data;
    reg_wr_o <= wr;
    reg_rd_o <= ~wr;
    @(posedge mclk_i);
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~addr;
    reg_wdata_o <= ~data;
  endtask : access
endmodule : host_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import uart_regs_pkg::*;
  logic mclk_i = 0, nrst_i = 0, soft_rst_i = 0, enhanced_en_i = 0, fifo_en_i = 0;
  logic rx_fifo_clear_i = 0, tx_fifo_clear_i = 0, rx_push_i = 0, tx_pop_i = 0;
  logic int_pending_i = 0, modem_change_i = 0, rx_pin_i = 1, rd_seen = 0;
  logic [7:0] line_control_i = 8'h00, rx_data_i = 8'h00, d, reg_rdata_o, tx_head_o;
  logic [7:0] divisor_low_o, int_enables_o, reg_wdata_i;
  logic [3:0] reg_addr_i;
  logic [1:0] tx_trigger_i = 2'b00;
  logic reg_wr_i, reg_rd_i, tx_avail_o, rx_avail_o, tx_ready_irq_o, sleep_o, osc_en_o;
  logic [7:0] exp_q[$];
  int n_fail = 0, num_checks = 0, cap, transmit_holding;

  always #2.5 mclk_i = ~mclk_i;

  host_model host (.mclk_i(mclk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));

  uart_holding_and_irq_enable_regs #(.DEPTH(FIFO_DEPTH)) uut (.mclk_i(mclk_i),
    .nrst_i(nrst_i), .soft_rst_i(soft_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .line_control_i(line_control_i), .enhanced_en_i(enhanced_en_i), .fifo_en_i(fifo_en_i),
    .tx_trigger_i(tx_trigger_i), .rx_fifo_clear_i(rx_fifo_clear_i),
    .tx_fifo_clear_i(tx_fifo_clear_i), .rx_push_i(rx_push_i), .rx_data_i(rx_data_i),
    .tx_pop_i(tx_pop_i), .int_pending_i(int_pending_i), .modem_change_i(modem_change_i),
    .rx_pin_i(rx_pin_i), .tx_head_o(tx_head_o), .tx_avail_o(tx_avail_o),
    .rx_avail_o(rx_avail_o), .divisor_low_o(divisor_low_o), .int_enables_o(int_enables_o),
    .tx_ready_irq_o(tx_ready_irq_o), .sleep_o(sleep_o), .osc_en_o(osc_en_o));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick

  task automatic expect_rd(input logic [3:0] addr, input logic [7:0] exp);
    exp_q.push_back(exp);
    host.access(1'b0, addr, 8'h00);
  endtask : expect_rd

  // Read data shows one cycle after the strobe is taken
  always @(posedge mclk_i) begin
    if (rd_seen) check("reg_rdata_o", reg_rdata_o, exp_q.pop_front());
    rd_seen <= reg_rd_i;
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    complete_run();
  end

  initial begin
    d = 8'($urandom(32'h8697_3040));
    tick(20);
    nrst_i <= 1'b1;
    tick(2);
    check("divisor_low_o", divisor_low_o, RST_DIVISOR_LOW);
    check("int_enables_o", int_enables_o, RST_INT_ENABLES);
    expect_rd(OFS_INT_ENABLES, RST_INT_ENABLES);
    host.access(1'b1, OFS_INT_ENABLES, 8'hFF);
    expect_rd(OFS_INT_ENABLES, 8'h0F);
    enhanced_en_i <= 1'b1;
    repeat (4) begin
      d = 8'($urandom);
      host.access(1'b1, OFS_INT_ENABLES, d);
      tick(2);
      check("int_enables_o", int_enables_o, d);
    end
    enhanced_en_i <= 1'b0;
    host.access(1'b1, OFS_INT_ENABLES, 8'h00);
    expect_rd(OFS_INT_ENABLES, {d[7:4], 4'h0});
    fifo_en_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_i);
      rx_data_i <= 8'($urandom);
      rx_push_i <= 1'b1;
      @(posedge mclk_i);
      rx_push_i <= 1'b0;
      exp_q.push_back(rx_data_i);
    end
    for (int i = 0; i < 3; i++) host.access(1'b0, OFS_HOLDING, 8'h00);
    tick(3);
    check("rx_avail_o", 8'(rx_avail_o), 8'h00);
    line_control_i <= 8'h80;
    host.access(1'b1, OFS_HOLDING, d);
    line_control_i <= LCR_ENHANCED_ACCESS;
    host.access(1'b1, OFS_HOLDING, ~d);
    line_control_i <= 8'h00;
    tick(2);
    check("divisor_low_o", divisor_low_o, d);
    soft_rst_i <= 1'b1;
    tick(1);
    soft_rst_i <= 1'b0;
    tick(3);
    check("divisor_low_o", divisor_low_o, d);
    check("int_enables_o", int_enables_o, RST_INT_ENABLES);
    enhanced_en_i <= 1'b1;
    host.access(1'b1, OFS_INT_ENABLES, 8'h02);
    for (int m = 0; m < 2; m++) begin
      fifo_en_i <= m[0];
      cap = (m == 1) ? FIFO_DEPTH : 1;
      tick(2);
      for (int i = 0; i <= cap; i++) host.access(1'b1, OFS_HOLDING, 8'(i + 16));
      tick(2);
      check("tx_ready_irq_o", 8'(tx_ready_irq_o), 8'h00);
      for (int i = 0; i < cap; i++) begin
        tx_trigger_i <= 2'($urandom);
        tick(2);
        transmit_holding = (tx_trigger_i == 2'b00) ? TX_TRIG_0 : (tx_trigger_i == 2'b01) ? TX_TRIG_1 :
          (tx_trigger_i == 2'b10) ? TX_TRIG_2 : TX_TRIG_3;
        check("tx_ready_irq_o", 8'((m == 1) && (i > transmit_holding)), 8'(tx_ready_irq_o));
        check("tx_head_o", tx_head_o, 8'(i + 16));
        tx_pop_i <= 1'b1;
        tick(1);
        tx_pop_i <= 1'b0;
        tick(2);
      end
      check("tx_avail_o", 8'(tx_avail_o), 8'h00);
      check("tx_ready_irq_o", 8'(tx_ready_irq_o), 8'h01);
    end
    host.access(1'b1, OFS_INT_ENABLES, 8'h10);
    int_pending_i <= 1'b1;
    tick(5);
    check("sleep_o", 8'(sleep_o), 8'h00);
    int_pending_i <= 1'b0;
    tick(5);
    check("sleep_o", 8'(sleep_o), 8'h01);
    check("osc_en_o", 8'(osc_en_o), 8'h00);
    rx_pin_i <= 1'b0;
    tick(4);
    check("sleep_o", 8'(sleep_o), 8'h00);
    rx_pin_i <= 1'b1;
    tick(5);
    modem_change_i <= 1'b1;
    tick(1);
    modem_change_i <= 1'b0;
    tick(2);
    check("osc_en_o", 8'(osc_en_o), 8'h01);
    tick(5);
    host.access(1'b1, OFS_HOLDING, d);
    tick(3);
    check("sleep_o", 8'(sleep_o), 8'h00);
    tick(4);
    complete_run();
  end
endmodule : tb_top
